// ==== hdl/sbc_pkg.sv ====
// constants and carriers for soft reset and memory self-test control
package sbc_pkg;

    // ------------------------------------------------------------
    // register map of the parallel register interface
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CHIP_SOFT_RESET = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_SELFTEST_CMD = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL_IRQ = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h07;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_RUN_SELFTEST = 7;
    localparam int BIT_SELFTEST_DONE = 6;
    localparam int BIT_SELFTEST_FAIL = 5;
    localparam int BIT_COMPLETE_EVENT = 1;
    localparam int BIT_EVENT_MASK = 1;
    localparam int BIT_GLOBAL_IRQ_EN = 0;

    // ------------------------------------------------------------
    // reset values and test patterns
    // ------------------------------------------------------------
    localparam logic RST_MASK = 1'b1;
    localparam logic RST_GIE = 1'b0;
    localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
    localparam logic [DATA_W-1:0] PAT_A = 8'h55;
    localparam logic [DATA_W-1:0] PAT_B = 8'hAA;

    // ------------------------------------------------------------
    // store geometry and run time
    // ------------------------------------------------------------
    localparam int STORE_AW = 8;
    localparam int STORE_DW = 8;
    localparam int TIMER_W = 32;
    localparam int RUN_TIME_MS = 2800;
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int RUN_CYCLES_DFLT = RUN_TIME_MS * CLK_FREQ_KHZ;

    // march sequence phases
    typedef enum logic [2:0] {
        MARCH_IDLE,
        MARCH_W0,
        MARCH_R0,
        MARCH_W1,
        MARCH_R1,
        MARCH_DRAIN,
        MARCH_DONE
    } sbc_march_e;

    // one host bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sbc_bus_req_s;

    // control state of the top block
    typedef struct packed {
        logic soft_reset;
        logic run;
        logic running;
        logic done;
        logic fail;
        logic status_evt;
        logic mask;
        logic global_irq_enable;
        logic [TIMER_W-1:0] timer;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic evt_pulse;
    } sbc_ctrl_s;

    localparam sbc_ctrl_s CTRL_RESET = '{
        soft_reset: 1'b0, run: 1'b0, running: 1'b0, done: 1'b0, fail: 1'b0,
        status_evt: 1'b0, mask: RST_MASK, global_irq_enable: RST_GIE, timer: '0,
        rdata: RST_RDATA, irq: 1'b0, evt_pulse: 1'b0};

endpackage

// ==== hdl/sbc_store.sv ====
// one internal store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sbc_store #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    output logic [DW-1:0] o_rdata
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DW-1:0] mem [0:(1<<AW)-1];
    typedef struct packed {
        logic [DW-1:0] rdata;
    } sbc_store_s;
    sbc_store_s r;
    sbc_store_s next_r;

    // read data always leaves through a register
    always_comb begin
        next_r = r;
        next_r.rdata = mem[i_addr];
    end

    // array has no reset: contents are undefined until written
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_rdata = r.rdata;
endmodule
`default_nettype wire

// ==== hdl/sbc_march.sv ====
// march test engine driving both stores in step
`timescale 1ns/1ps
`default_nettype none
module sbc_march import sbc_pkg::*; #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [DW-1:0] i_rdata_data,
    input wire logic [DW-1:0] i_rdata_conn,
    output logic o_we,
    output logic [AW-1:0] o_addr,
    output logic [DW-1:0] o_wdata,
    output logic o_finished,
    output logic o_fail
);
    typedef struct packed {
        sbc_march_e phase;
        logic [AW-1:0] addr;
        logic [1:0] check;
        logic [DW-1:0] expect_v;
        logic we;
        logic [DW-1:0] wdata;
        logic fail;
        logic finished;
    } sbc_march_s;

    localparam logic [AW-1:0] LAST_ADDR = '1;
    localparam sbc_march_s MARCH_RESET = '{phase: MARCH_IDLE, default: '0};
    sbc_march_s r;
    sbc_march_s next_r;

    // ------------------------------------------------------------
    // sequence: write A, read A, write B, read B, over all words
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.we = 1'b0;
        next_r.check = {r.check[0], 1'b0};
        // read data lags the address by one edge
        if (r.check[1] && (i_rdata_data != r.expect_v || i_rdata_conn != r.expect_v)) begin
            next_r.fail = 1'b1;
        end
        case (r.phase)
            MARCH_IDLE: begin
                next_r.phase = MARCH_W0;
                next_r.addr = '0;
                next_r.we = 1'b1;
                next_r.wdata = PAT_A;
                next_r.fail = 1'b0;
            end
            MARCH_W0, MARCH_W1: begin
                if (r.addr == LAST_ADDR) begin
                    next_r.phase = (r.phase == MARCH_W0) ? MARCH_R0 : MARCH_R1;
                    next_r.addr = '0;
                    next_r.check[0] = 1'b1;
                    next_r.expect_v = r.wdata;
                end else begin
                    next_r.addr = r.addr + 1'b1;
                    next_r.we = 1'b1;
                end
            end
            MARCH_R0: begin
                if (r.addr == LAST_ADDR) begin
                    next_r.phase = MARCH_W1;
                    next_r.addr = '0;
                    next_r.we = 1'b1;
                    next_r.wdata = PAT_B;
                end else begin
                    next_r.addr = r.addr + 1'b1;
                    next_r.check[0] = 1'b1;
                end
            end
            MARCH_R1: begin
                if (r.addr == LAST_ADDR) begin
                    next_r.phase = MARCH_DRAIN;
                end else begin
                    next_r.addr = r.addr + 1'b1;
                    next_r.check[0] = 1'b1;
                end
            end
            MARCH_DRAIN: begin
                if (r.check == 2'b00) begin
                    next_r.phase = MARCH_DONE;
                    next_r.finished = 1'b1;
                end
            end
            MARCH_DONE: begin
                next_r.finished = 1'b1;
            end
            default: begin
                next_r = MARCH_RESET;
            end
        endcase
        // leaving the run drops the test at once
        if (!i_enable) begin
            next_r = MARCH_RESET;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            r <= MARCH_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign o_we = r.we;
    assign o_addr = r.addr;
    assign o_wdata = r.wdata;
    assign o_finished = r.finished;
    assign o_fail = r.fail;
endmodule
`default_nettype wire

// ==== hdl/sbc_ctrl.sv ====
// soft reset and memory self-test control with its registers
//
// Notes on behaviour
// - writing soft_reset 1 resets the chip
// - all other registers held at defaults
// - reset holds until soft_reset written 0
// - bus interface unaffected, write completes normally
// - unused bits always read zero
// - run_selftest 1 tests both stores
// - completion sets done and status event
// - event interrupt only when not masked
// - selftest_done readable at any time
// - done holds until run_selftest written 0
// - run lasts about 2.8 seconds
// - selftest_fail reports memory errors found
// - result valid once completion is signalled
// - test may overwrite store contents
// - interrupt also needs global_irq_enable set
`timescale 1ns/1ps
`default_nettype none
module sbc_ctrl import sbc_pkg::*; #(
    parameter int unsigned RUN_CYCLES = RUN_CYCLES_DFLT,
    parameter int AW = STORE_AW,
    parameter int DW = STORE_DW
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire sbc_bus_req_s i_bus,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_chip_soft_reset,
    output logic o_irq,
    output logic o_selftest_complete_event,
    output logic o_selftest_busy
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(RUN_CYCLES - 1);

    sbc_ctrl_s r;
    sbc_ctrl_s next_r;
    logic eng_we;
    logic [AW-1:0] eng_addr;
    logic [DW-1:0] eng_wdata;
    logic [DW-1:0] data_rdata;
    logic [DW-1:0] conn_rdata;
    logic eng_finished;
    logic eng_fail;
    logic wr_soft;
    logic wr_cmd;

    assign wr_soft = i_bus.wr && hit(i_bus.addr, OFS_CHIP_SOFT_RESET);
    assign wr_cmd = i_bus.wr && hit(i_bus.addr, OFS_SELFTEST_CMD);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] a,
                                                      input sbc_ctrl_s s);
        logic [DATA_W-1:0] v;
        v = '0;
        if (hit(a, OFS_CHIP_SOFT_RESET)) begin
            v[BIT_SOFT_RESET] = s.soft_reset;
        end else if (hit(a, OFS_SELFTEST_CMD)) begin
            v[BIT_RUN_SELFTEST] = s.run;
            v[BIT_SELFTEST_DONE] = s.done;
            v[BIT_SELFTEST_FAIL] = s.fail;
        end else if (hit(a, OFS_GLOBAL_IRQ)) begin
            v[BIT_GLOBAL_IRQ_EN] = s.global_irq_enable;
        end else if (hit(a, OFS_IRQ_STATUS)) begin
            v[BIT_COMPLETE_EVENT] = s.status_evt;
        end else if (hit(a, OFS_IRQ_MASK)) begin
            v[BIT_EVENT_MASK] = s.mask;
        end
        read_value = v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.evt_pulse = 1'b0;
        // held in soft reset: everything to defaults but the bus side
        if (r.soft_reset) begin
            next_r = CTRL_RESET;
            next_r.soft_reset = r.soft_reset;
            next_r.rdata = r.rdata;
        end else begin
            // run bit: a one while idle starts, a zero ends and clears done
            if (wr_cmd) begin
                if (i_bus.wdata[BIT_RUN_SELFTEST] && !r.run) begin
                    next_r.run = 1'b1;
                    next_r.running = 1'b1;
                    next_r.timer = '0;
                    next_r.fail = 1'b0;
                end else if (!i_bus.wdata[BIT_RUN_SELFTEST]) begin
                    next_r.run = 1'b0;
                    next_r.running = 1'b0;
                    next_r.done = 1'b0;
                end
            end
            if (i_bus.wr && hit(i_bus.addr, OFS_GLOBAL_IRQ)) begin
                next_r.global_irq_enable = i_bus.wdata[BIT_GLOBAL_IRQ_EN];
            end
            if (i_bus.wr && hit(i_bus.addr, OFS_IRQ_MASK)) begin
                next_r.mask = i_bus.wdata[BIT_EVENT_MASK];
            end
            // status bit is write-one-to-clear
            if (i_bus.wr && hit(i_bus.addr, OFS_IRQ_STATUS) &&
                i_bus.wdata[BIT_COMPLETE_EVENT]) begin
                next_r.status_evt = 1'b0;
            end
            // run clock counts wall time, saturating at the end
            if (r.running && r.timer != TIMER_LAST) begin
                next_r.timer = r.timer + 1'b1;
            end
            // completion needs both the full time and a finished march;
            // placed last so a set beats a clear in the same cycle
            if (r.running && r.timer == TIMER_LAST && eng_finished &&
                !(wr_cmd && !i_bus.wdata[BIT_RUN_SELFTEST])) begin
                next_r.running = 1'b0;
                next_r.done = 1'b1;
                next_r.fail = eng_fail;
                next_r.status_evt = 1'b1;
                next_r.evt_pulse = 1'b1;
            end else if (r.running && r.timer == TIMER_LAST && eng_finished) begin
                next_r.done = 1'b1;
                next_r.fail = eng_fail;
                next_r.status_evt = 1'b1;
                next_r.evt_pulse = 1'b1;
            end
        end
        // soft reset bit is never reset by itself and always writable
        if (wr_soft) begin
            next_r.soft_reset = i_bus.wdata[BIT_SOFT_RESET];
        end
        // reads answer from current state, reserved bits zero
        if (i_bus.rd) begin
            next_r.rdata = read_value(i_bus.addr, r);
        end
        // interrupt gated by the event mask and the global enable
        next_r.irq = r.global_irq_enable && !r.mask && r.status_evt && !r.soft_reset;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            r <= CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // engine and the two stores under test
    // ------------------------------------------------------------
    sbc_march #(
        .AW(AW),
        .DW(DW)
    ) u_march (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_enable(r.running),
        .i_rdata_data(data_rdata),
        .i_rdata_conn(conn_rdata),
        .o_we(eng_we),
        .o_addr(eng_addr),
        .o_wdata(eng_wdata),
        .o_finished(eng_finished),
        .o_fail(eng_fail)
    );

    // data store stand-in
    sbc_store #(
        .AW(AW),
        .DW(DW)
    ) u_data_store (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(eng_we),
        .i_addr(eng_addr),
        .i_wdata(eng_wdata),
        .o_rdata(data_rdata)
    );

    // connection store stand-in
    sbc_store #(
        .AW(AW),
        .DW(DW)
    ) u_conn_store (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(eng_we),
        .i_addr(eng_addr),
        .i_wdata(eng_wdata),
        .o_rdata(conn_rdata)
    );

    // ------------------------------------------------------------
    // outputs, all straight from state flops
    // ------------------------------------------------------------
    assign o_rdata = r.rdata;
    assign o_chip_soft_reset = r.soft_reset;
    assign o_irq = r.irq;
    assign o_selftest_complete_event = r.evt_pulse;
    assign o_selftest_busy = r.running;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    // soft reset entry, hold, release and what it parks
    AST_SOFT_SET: assert property (wr_soft && i_bus.wdata[BIT_SOFT_RESET]
        |=> o_chip_soft_reset)
        else $error("soft reset not entered after write of one");

    AST_SOFT_HOLD: assert property (o_chip_soft_reset && !wr_soft |=> o_chip_soft_reset)
        else $error("soft reset released without a write of zero");

    AST_SOFT_DEFAULTS: assert property (o_chip_soft_reset
        |=> !r.run && !r.done && !r.global_irq_enable && r.mask)
        else $error("register kept a value during soft reset");

    AST_SOFT_RELEASE: assert property (o_chip_soft_reset && wr_soft
        && !i_bus.wdata[BIT_SOFT_RESET] |=> !o_chip_soft_reset)
        else $error("soft reset not released by a write of zero");

    AST_SOFT_QUIET: assert property (o_chip_soft_reset
        |=> !o_selftest_busy && !o_irq && !o_selftest_complete_event)
        else $error("activity seen while held in soft reset");

    // bus side keeps answering while the rest is parked
    AST_SOFT_READ: assert property (o_chip_soft_reset && $past(o_chip_soft_reset)
        && i_bus.rd && hit(i_bus.addr, OFS_IRQ_MASK)
        |=> o_rdata[BIT_EVENT_MASK] == RST_MASK)
        else $error("read during soft reset did not answer");

    AST_SOFT_RSVD_ZERO: assert property (i_bus.rd && hit(i_bus.addr, OFS_CHIP_SOFT_RESET)
        |=> o_rdata[DATA_W-1:BIT_SOFT_RESET+1] == '0)
        else $error("reserved soft reset bits read nonzero");

    AST_RESERVED_ZERO: assert property (i_bus.rd && hit(i_bus.addr, OFS_SELFTEST_CMD)
        |=> o_rdata[BIT_SELFTEST_FAIL-1:0] == '0)
        else $error("reserved command bits read nonzero");

    // run, completion and result
    AST_START: assert property (wr_cmd && i_bus.wdata[BIT_RUN_SELFTEST] && !r.run
        && !r.soft_reset && !wr_soft |=> o_selftest_busy && r.timer == '0)
        else $error("self-test did not start");

    AST_TIMER_STEP: assert property (o_selftest_busy && !o_chip_soft_reset
        && r.timer != TIMER_LAST |=> r.timer == $past(r.timer) + 1'b1)
        else $error("run timer skipped a cycle");

    AST_RUN_TIME: assert property ($rose(r.done) |-> $past(r.timer) == TIMER_LAST)
        else $error("completion before the full run time");

    AST_DONE_EVENT: assert property ($rose(r.done)
        |-> r.status_evt && o_selftest_complete_event)
        else $error("done set without the completion event");

    AST_EVENT_PULSE: assert property (o_selftest_complete_event
        |=> !o_selftest_complete_event)
        else $error("completion event longer than one cycle");

    AST_BUSY_DROP: assert property (o_selftest_complete_event |-> !o_selftest_busy)
        else $error("still busy after completion");

    AST_FAIL_LATCH: assert property ($rose(r.done) |-> r.fail == $past(eng_fail))
        else $error("result not taken from the march engine");

    AST_FAIL_STABLE: assert property (r.done && $past(r.done) |-> $stable(r.fail))
        else $error("result changed after completion");

    AST_DONE_HOLD: assert property (r.done && !(wr_cmd && !i_bus.wdata[BIT_RUN_SELFTEST])
        && !r.soft_reset |=> r.done)
        else $error("done dropped without a clear of run");

    // a late clear must not hide a completion landing in the same cycle
    AST_DONE_CLEAR: assert property (r.done && wr_cmd && !i_bus.wdata[BIT_RUN_SELFTEST]
        && !r.soft_reset && !(r.running && r.timer == TIMER_LAST && eng_finished)
        |=> !r.done)
        else $error("done not cleared by a write of zero to run");

    AST_ABORT: assert property (wr_cmd && !i_bus.wdata[BIT_RUN_SELFTEST] && !r.soft_reset
        |=> !o_selftest_busy)
        else $error("clearing run did not stop the test");

    AST_DONE_READ: assert property (i_bus.rd && hit(i_bus.addr, OFS_SELFTEST_CMD)
        |=> o_rdata[BIT_SELFTEST_DONE] == $past(r.done))
        else $error("done flag not readable");

    AST_FAIL_READ: assert property (i_bus.rd && hit(i_bus.addr, OFS_SELFTEST_CMD)
        |=> o_rdata[BIT_SELFTEST_FAIL] == $past(r.fail))
        else $error("fail flag not readable");

    // interrupt: never without both enables, always with them and a pending event outside soft reset
    AST_IRQ_GATE: assert property (o_irq |-> $past(r.global_irq_enable) && !$past(r.mask))
        else $error("interrupt raised while masked or disabled");

    AST_IRQ_RAISE: assert property (r.global_irq_enable && !r.mask && r.status_evt && !r.soft_reset
        |=> o_irq)
        else $error("interrupt missing for an enabled event");
endmodule
`default_nettype wire

// ==== bench/sbc_host_model.sv ====
// host microprocessor model driving byte register reads and writes
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model import sbc_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic [DATA_W-1:0] i_rdata,
    output var sbc_bus_req_s o_bus
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // bus quiet from time zero
    initial begin
        o_bus = '0;
    end

    // one-cycle write strobe; released fields show inverted values, not stale ones
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge i_sys_clk);
        o_bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge i_sys_clk);
        o_bus = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // one-cycle read strobe; data sampled half a cycle after the taking edge
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge i_sys_clk);
        o_bus = '{addr: a, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b1};
        @(negedge i_sys_clk);
        d = i_rdata;
        o_bus = '{addr: ~a, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b0};
    endtask

    // closing sequence after a self-test run
    task automatic end_selftest();
        wr_reg(OFS_SELFTEST_CMD, 8'h00);
        wr_reg(OFS_CHIP_SOFT_RESET, 8'h01);
        wr_reg(OFS_CHIP_SOFT_RESET, 8'h00);
    endtask
endmodule
`default_nettype wire

// ==== bench/test_sbc_ctrl.sv ====
// self-checking bench for soft reset and memory self-test control
`timescale 1ns/1ps
`default_nettype none
`define SBC_CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module test_sbc_ctrl import sbc_pkg::*;;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    // short run keeps simulation brief; march still fits inside it
    localparam int unsigned RUN = 2000;
    localparam logic [7:0] MASK_BIT = 8'(1 << BIT_EVENT_MASK);
    localparam logic [7:0] RUN_BIT = 8'(1 << BIT_RUN_SELFTEST);
    localparam logic [7:0] DONE_BIT = 8'(1 << BIT_SELFTEST_DONE);
    localparam logic [7:0] EVT_BIT = 8'(1 << BIT_COMPLETE_EVENT);
    logic i_sys_clk;
    logic i_reset_n;
    sbc_bus_req_s bus;
    logic [DATA_W-1:0] rdata;
    logic chip_rst;
    logic irq;
    logic evt;
    logic busy;
    int checks;
    int n_fail;
    int cyc;

    sbc_ctrl #(.RUN_CYCLES(RUN), .AW(STORE_AW), .DW(STORE_DW)) sbc_ctrl_inst (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_bus(bus),
        .o_rdata(rdata),
        .o_chip_soft_reset(chip_rst),
        .o_irq(irq),
        .o_selftest_complete_event(evt),
        .o_selftest_busy(busy)
    );

    sbc_host_model sbc_host_model_inst (
        .i_sys_clk(i_sys_clk),
        .i_rdata(rdata),
        .o_bus(bus)
    );

    // free-running 25 MHz clock
    initial begin
        i_sys_clk = 1'b0;
    end
    always #20 i_sys_clk = ~i_sys_clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // verdict in one place, reached by the normal end and by timeouts
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        sbc_host_model_inst.rd_reg(a, d);
        `SBC_CHK(d, exp)
    endtask

    // bounded wait for the completion pulse, counting falling edges
    task automatic wait_event(output int n);
        n = 0;
        while (evt !== 1'b1) begin
            @(negedge i_sys_clk);
            n++;
            if (n > 4 * RUN) begin
                n_fail++;
                $display("CHECK FAILED at %0t: no completion event", $time);
                tally_and_finish();
            end
        end
    endtask

    task automatic settle_chk_irq(input logic exp);
        repeat (2) @(negedge i_sys_clk);
        `SBC_CHK(irq, exp)
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        checks = 0;
        n_fail = 0;
        i_reset_n = 1'b0;
        repeat (16) @(negedge i_sys_clk);
        i_reset_n = 1'b1;

        // defaults after the reset pin, unmapped place reads zero
        chk_rd(OFS_CHIP_SOFT_RESET, 8'h00);
        chk_rd(OFS_SELFTEST_CMD, 8'h00);
        chk_rd(OFS_GLOBAL_IRQ, 8'h00);
        chk_rd(OFS_IRQ_STATUS, 8'h00);
        chk_rd(OFS_IRQ_MASK, MASK_BIT);
        chk_rd(8'h10, 8'h00);
        `SBC_CHK({chip_rst, irq, busy}, 3'b000)
        $display("test defaults finished");

        // soft reset: defaults restored, writes ignored, bus still alive
        sbc_host_model_inst.wr_reg(OFS_GLOBAL_IRQ, 8'h01);
        sbc_host_model_inst.wr_reg(OFS_IRQ_MASK, 8'h00);
        sbc_host_model_inst.wr_reg(OFS_CHIP_SOFT_RESET, 8'hFF);
        `SBC_CHK(chip_rst, 1'b1)
        chk_rd(OFS_CHIP_SOFT_RESET, 8'h01);
        chk_rd(OFS_GLOBAL_IRQ, 8'h00);
        chk_rd(OFS_IRQ_MASK, MASK_BIT);
        sbc_host_model_inst.wr_reg(OFS_SELFTEST_CMD, RUN_BIT);
        repeat (4) @(negedge i_sys_clk);
        `SBC_CHK(busy, 1'b0)
        `SBC_CHK(chip_rst, 1'b1)
        sbc_host_model_inst.wr_reg(OFS_CHIP_SOFT_RESET, 8'h00);
        `SBC_CHK(chip_rst, 1'b0)
        $display("test soft reset finished");

        // full self-test run with interrupt enabled and unmasked
        sbc_host_model_inst.wr_reg(OFS_GLOBAL_IRQ, 8'h01);
        sbc_host_model_inst.wr_reg(OFS_IRQ_MASK, 8'h00);
        sbc_host_model_inst.wr_reg(OFS_SELFTEST_CMD, 8'hFF);
        `SBC_CHK(busy, 1'b1)
        chk_rd(OFS_SELFTEST_CMD, RUN_BIT);
        wait_event(cyc);
        `SBC_CHK(((cyc + 2) >= RUN - 4) && ((cyc + 2) <= RUN + 4), 1'b1)
        @(negedge i_sys_clk);
        `SBC_CHK({evt, irq, busy}, 3'b010)
        chk_rd(OFS_SELFTEST_CMD, RUN_BIT | DONE_BIT);
        chk_rd(OFS_IRQ_STATUS, EVT_BIT);
        repeat (50) @(negedge i_sys_clk);
        chk_rd(OFS_SELFTEST_CMD, RUN_BIT | DONE_BIT);
        sbc_host_model_inst.wr_reg(OFS_IRQ_MASK, MASK_BIT);
        settle_chk_irq(1'b0);
        sbc_host_model_inst.wr_reg(OFS_IRQ_MASK, 8'h00);
        settle_chk_irq(1'b1);
        sbc_host_model_inst.wr_reg(OFS_GLOBAL_IRQ, 8'h00);
        settle_chk_irq(1'b0);
        sbc_host_model_inst.wr_reg(OFS_IRQ_STATUS, EVT_BIT);
        chk_rd(OFS_IRQ_STATUS, 8'h00);
        sbc_host_model_inst.end_selftest();
        chk_rd(OFS_SELFTEST_CMD, 8'h00);
        chk_rd(OFS_IRQ_MASK, MASK_BIT);
        `SBC_CHK(chip_rst, 1'b0)
        $display("test self-test run finished");

        // abort in mid-run: clearing the run bit stops the test, no event follows
        sbc_host_model_inst.wr_reg(OFS_SELFTEST_CMD, RUN_BIT);
        repeat (100) @(negedge i_sys_clk);
        sbc_host_model_inst.wr_reg(OFS_SELFTEST_CMD, 8'h00);
        `SBC_CHK(busy, 1'b0)
        cyc = 0;
        repeat (2 * RUN) begin
            @(negedge i_sys_clk);
            cyc += (evt !== 1'b0) ? 1 : 0;
        end
        `SBC_CHK(cyc, 0)
        chk_rd(OFS_SELFTEST_CMD, 8'h00);
        $display("test abort finished");

        tally_and_finish();
    end
endmodule
`default_nettype wire
